// file: rtl/fex_core.sv
`timescale 1ns/1ps
module fex_core
    import fex_pkg::*;
(
    input logic aclk,
    input logic aresetn,
    input logic ce,
    input logic [AXI_AW-1:0] s_axi_awaddr,
    input logic s_axi_awvalid,
    output logic s_axi_awready,
    input logic [31:0] s_axi_wdata,
    input logic [3:0] s_axi_wstrb,
    input logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic [AXI_AW-1:0] s_axi_araddr,
    input logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input logic s_axi_rready,
    output logic [PA_W-1:0] prog_addr,
    input logic [15:0] prog_data,
    input logic [7:0] io_vector_rdata,
    output fex_byte_port_s io_vector_wr,
    input logic [7:0] scratch_store_rdata,
    output fex_byte_port_s scratch_store_wr
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] len_mask(input logic [2:0] rl);
        logic [8:0] m;
        m = (9'h001 << rl) - 9'h001;
        len_mask = (rl == LEN_FULL) ? BYTE_FULL : m[7:0];
    endfunction

    function automatic logic [7:0] rot_right(input logic [7:0] v,
                                             input logic [2:0] n);
        logic [15:0] w;
        w = {v, v} >> n;
        rot_right = w[7:0];
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    fex_state_e state;
    fex_instr_s ins;
    logic [PA_W-1:0] pc;
    logic [PA_W-1:0] exec_address_reg;
    logic in_xec;
    logic [7:0] wreg [0:7];
    logic carry_flag;
    logic [7:0] left_bank_select;
    logic [7:0] right_bank_select;
    logic run;
    logic step_req;
    logic [3:0] cyc_cnt;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire go = run | step_req;
    wire start = ce & (state == FEX_FETCH) & go;
    wire exec = ce & (state == FEX_EXEC);
    wire alu_op = ~ins.op[2];
    wire s_reg = ~ins.src[4];
    wire d_reg = ~ins.dst[4];
    wire [7:0] lit8 = {ins.rl, ins.dst};
    wire [4:0] lit5 = ins.dst;

    // Register read; bank selects and unassigned codes give zero
    logic [7:0] src_reg_val;
    always_comb begin
        src_reg_val = BYTE_RESET;
        if (ins.src <= CODE_WORK6) begin
            src_reg_val = wreg[ins.src[2:0]];
        end else if (ins.src == CODE_CARRY) begin
            src_reg_val = {7'h00, carry_flag};
        end else if (ins.src == CODE_SEVENTH) begin
            src_reg_val = wreg[IDX_SEVENTH];
        end
    end

    // Field source: position code counts from the left
    wire [2:0] src_sh = POS_LSB - ins.src[2:0];
    wire [7:0] src_byte = ins.src[3] ? scratch_store_rdata : io_vector_rdata;
    wire [7:0] src_shifted = src_byte >> src_sh;
    wire [7:0] src_field = src_shifted & len_mask(ins.rl);
    wire full_xfer = (ins.op == OP_MOVE) & ~s_reg & ~d_reg
                     & (ins.src[3] != ins.dst[3]);
    wire [7:0] src_rot = (s_reg & d_reg) ? rot_right(src_reg_val, ins.rl)
                         : src_reg_val;
    wire [7:0] alu_src = full_xfer ? src_byte
                         : (s_reg ? src_rot : src_field);
    wire [8:0] sum9 = {1'b0, alu_src} + {1'b0, wreg[CODE_AUX[2:0]]};

    logic [7:0] alu_res;
    always_comb begin
        case (ins.op)
            OP_ADD: alu_res = sum9[7:0];
            OP_AND: alu_res = alu_src & wreg[CODE_AUX[2:0]];
            OP_XOR: alu_res = alu_src ^ wreg[CODE_AUX[2:0]];
            default: alu_res = alu_src;
        endcase
    end

    // Destination: literal load names it in the source slot
    wire is_lit = (ins.op == OP_LIT);
    wire [4:0] wr_code = is_lit ? ins.src : ins.dst;
    wire wr_reg = ~wr_code[4];
    wire wr_en = exec & (alu_op | is_lit);
    wire [7:0] lit_val = wr_reg ? lit8 : ({3'h0, lit5} & len_mask(ins.rl));
    wire [7:0] wr_val = is_lit ? lit_val : alu_res;

    // Field merge into the destination byte
    wire [2:0] dst_sh = POS_LSB - wr_code[2:0];
    wire [7:0] dst_old = wr_code[3] ? scratch_store_rdata : io_vector_rdata;
    wire [7:0] dst_mask = full_xfer ? BYTE_FULL
                          : 8'(len_mask(ins.rl) << dst_sh);
    wire [7:0] dst_ins = full_xfer ? wr_val : 8'(wr_val << dst_sh);
    wire [7:0] merged = (dst_old & ~dst_mask) | (dst_ins & dst_mask);

    logic [2:0] wr_idx;
    logic wr_idx_ok;
    always_comb begin
        wr_idx = wr_code[2:0];
        wr_idx_ok = wr_reg & (wr_code <= CODE_WORK6);
        if (wr_code == CODE_SEVENTH) begin
            wr_idx = IDX_SEVENTH;
            wr_idx_ok = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Program flow
    // ------------------------------------------------------------------
    wire [7:0] test_val = s_reg ? src_reg_val : src_field;
    wire [7:0] xec_sum = lit8 + src_reg_val;
    wire [4:0] xec_sum5 = lit5 + src_field[4:0];
    wire [PA_W-1:0] xec_target = s_reg
        ? {exec_address_reg[PA_W-1:8], xec_sum}
        : {exec_address_reg[PA_W-1:5], xec_sum5};
    wire bnz_taken = (ins.op == OP_BNZ) & (test_val != BYTE_RESET);
    wire [PA_W-1:0] bnz_target = s_reg
        ? {exec_address_reg[PA_W-1:8], lit8}
        : {exec_address_reg[PA_W-1:5], lit5};
    wire [PA_W-1:0] seq_next = pc + 13'h0001;

    logic [PA_W-1:0] next_ar;
    always_comb begin
        if (ins.op == OP_JUMP) begin
            next_ar = {ins.src, ins.rl, ins.dst};
        end else if (bnz_taken) begin
            next_ar = bnz_target;
        end else if (ins.op == OP_EXEC) begin
            next_ar = xec_target;
        end else begin
            next_ar = seq_next;
        end
    end
    wire [PA_W-1:0] next_pc = (ins.op == OP_EXEC) ? pc : next_ar;

    assign prog_addr = exec_address_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= FEX_FETCH;
            ins <= '0;
            pc <= PC_RESET;
            exec_address_reg <= PC_RESET;
            in_xec <= 1'b0;
            cyc_cnt <= 4'h0;
        end else if (ce) begin
            if (start) begin
                ins <= prog_data;
                state <= FEX_EXEC;
                cyc_cnt <= 4'h1;
            end else if (state == FEX_EXEC) begin
                exec_address_reg <= next_ar;
                pc <= next_pc;
                in_xec <= (ins.op == OP_EXEC);
                state <= FEX_FETCH;
                cyc_cnt <= cyc_cnt + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Working registers, flag and bank selects
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_wreg
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    wreg[g] <= BYTE_RESET;
                end else if (ce & wr_en & wr_idx_ok & (wr_idx == g)) begin
                    wreg[g] <= wr_val;
                end
            end
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            carry_flag <= 1'b0;
            left_bank_select <= BYTE_RESET;
            right_bank_select <= BYTE_RESET;
        end else if (ce) begin
            if (exec & (ins.op == OP_ADD)) begin
                carry_flag <= sum9[8];
            end
            if (wr_en & (wr_code == CODE_LEFT_BANK)) begin
                left_bank_select <= wr_val;
            end
            if (wr_en & (wr_code == CODE_RIGHT_BANK)) begin
                right_bank_select <= wr_val;
            end
        end
    end

    // ------------------------------------------------------------------
    // Byte buses
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            io_vector_wr.data <= BYTE_RESET;
            io_vector_wr.we <= 1'b0;
            scratch_store_wr.data <= BYTE_RESET;
            scratch_store_wr.we <= 1'b0;
        end else if (ce) begin
            io_vector_wr.we <= wr_en & ~wr_reg & ~wr_code[3];
            scratch_store_wr.we <= wr_en & ~wr_reg & wr_code[3];
            if (wr_en & ~wr_reg) begin
                io_vector_wr.data <= merged;
                scratch_store_wr.data <= merged;
            end
        end
    end
    assign io_vector_wr.addr = left_bank_select;
    assign scratch_store_wr.addr = right_bank_select;

    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    wire aw_take = ce & s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
    wire ar_take = ce & s_axi_arvalid & ~s_axi_rvalid;
    wire wr_ctrl = aw_take & (s_axi_awaddr == REG_CTRL) & s_axi_wstrb[0];
    wire aw_hit = (s_axi_awaddr == REG_CTRL) | (s_axi_awaddr == REG_STATUS)
                  | (s_axi_awaddr == REG_STATE);
    wire ar_hit = (s_axi_araddr == REG_CTRL) | (s_axi_araddr == REG_STATUS)
                  | (s_axi_araddr == REG_STATE);
    assign s_axi_awready = aw_take;
    assign s_axi_wready = aw_take;
    assign s_axi_arready = ar_take;

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (s_axi_araddr)
            REG_CTRL: begin
                rd_mux[CTRL_RUN] = run;
                rd_mux[CTRL_STEP] = step_req;
            end
            REG_STATUS: begin
                rd_mux[PA_W-1:0] = pc;
                rd_mux[STAT_CARRY] = carry_flag;
                rd_mux[STAT_RUN] = (state == FEX_EXEC);
                rd_mux[STAT_XEC] = in_xec;
            end
            REG_STATE: begin
                rd_mux[7:0] = wreg[CODE_AUX[2:0]];
                rd_mux[STATE_AR_LSB +: PA_W] = exec_address_reg;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run <= 1'b0;
            step_req <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (ce) begin
            if (wr_ctrl) begin
                run <= s_axi_wdata[CTRL_RUN];
            end
            // A new step request wins over the one being consumed
            step_req <= (step_req & ~start)
                        | (wr_ctrl & s_axi_wdata[CTRL_STEP]);
            if (aw_take) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= aw_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= ar_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_jump;
        @(posedge aclk) disable iff (!aresetn || !ce)
        (exec && ins.op == OP_JUMP)
            |=> (exec_address_reg == $past({ins.src, ins.rl, ins.dst}))
                && (pc == exec_address_reg);
    endproperty
    a_jump: assert property (p_jump)
        else $error("jump did not load the address field");

    property p_carry_only_add;
        @(posedge aclk) disable iff (!aresetn || !ce)
        $changed(carry_flag) |-> $past(exec && ins.op == OP_ADD);
    endproperty
    a_carry_only_add: assert property (p_carry_only_add)
        else $error("carry flag changed outside an add");

    property p_seq;
        @(posedge aclk) disable iff (!aresetn || !ce)
        (exec && alu_op && !in_xec)
            |=> exec_address_reg == $past(exec_address_reg) + 13'h0001;
    endproperty
    a_seq: assert property (p_seq)
        else $error("data instruction did not advance sequentially");

    property p_bnz_zero;
        @(posedge aclk) disable iff (!aresetn || !ce)
        (exec && ins.op == OP_BNZ && test_val == BYTE_RESET)
            |=> exec_address_reg == $past(pc) + 13'h0001;
    endproperty
    a_bnz_zero: assert property (p_bnz_zero)
        else $error("branch on zero source did not fall through");

    property p_bnz_taken;
        @(posedge aclk) disable iff (!aresetn || !ce)
        (exec && ins.op == OP_BNZ && s_reg && test_val != BYTE_RESET)
            |=> (exec_address_reg[7:0] == $past(lit8))
                && (exec_address_reg[PA_W-1:8]
                    == $past(exec_address_reg[PA_W-1:8]));
    endproperty
    a_bnz_taken: assert property (p_bnz_taken)
        else $error("taken branch did not replace low counter bits");

    property p_xec_hold;
        @(posedge aclk) disable iff (!aresetn || !ce)
        (exec && ins.op == OP_EXEC)
            |=> in_xec && (pc == $past(pc))
                && (exec_address_reg == $past(xec_target));
    endproperty
    a_xec_hold: assert property (p_xec_hold)
        else $error("execute did not fetch the formed address");

    property p_xec_return;
        @(posedge aclk) disable iff (!aresetn || !ce)
        (exec && in_xec && alu_op)
            |=> (pc == $past(pc) + 13'h0001) && !in_xec;
    endproperty
    a_xec_return: assert property (p_xec_return)
        else $error("sequence did not resume after executed target");

    property p_bank_select;
        @(posedge aclk) disable iff (!aresetn || !ce)
        (wr_en && wr_code == CODE_LEFT_BANK)
            |=> left_bank_select == $past(wr_val);
    endproperty
    a_bank_select: assert property (p_bank_select)
        else $error("left bank select not written");

    property p_instr_time;
        @(posedge aclk) disable iff (!aresetn || !ce)
        start |=> (state == FEX_EXEC) ##1 (state == FEX_FETCH)
                  && (cyc_cnt <= INSTR_CYC_MAX);
    endproperty
    a_instr_time: assert property (p_instr_time)
        else $error("instruction took longer than one instruction cycle");

    property p_field_keep;
        @(posedge aclk) disable iff (!aresetn || !ce)
        (wr_en && !wr_reg && !wr_code[3])
            |=> io_vector_wr.we
                && ((io_vector_wr.data & ~$past(dst_mask))
                    == ($past(io_vector_rdata) & ~$past(dst_mask)));
    endproperty
    a_field_keep: assert property (p_field_keep)
        else $error("bits outside the selected field were altered");

endmodule

// file: rtl/fex_pkg.sv
// Contract
// - Literal is 8 bits with register source, 5 bits with I/O or scratch field.
// - Opcode 0 move,1 add,2 and,3 xor,4 execute,5 branch,6 literal,7 jump.
// - Absolute jump carries a 13-bit address reaching 8192 locations.
// - Register to field writes merge low result bits, other bits kept.
// - Field source is right-justified, zero-extended; register gets full result.
// - Bank-select pseudo registers are write-only; reading them gives nothing.
// - Carry flag is source only and changes only on add.
// - Codes 00 aux, 01-06 work, 07 left bank, 10 carry, 11 seventh, 17 right.
// - Codes 20-27 select field LSB position in the selected byte.
// - Move copies source; register to register rotates right first.
// - Move between I/O byte and scratch byte always moves all 8 bits.
// - Add stores source plus aux; carry set on carry out, else cleared.
// - Register sources rotate for add/and/xor to a register; operands kept unless destination.
// - And stores bitwise AND, xor bitwise XOR, of source and aux.
// - Execute runs the instruction at address with low bits from literal+source.
// - After execute, sequence resumes unless target jumps or branches taken.
// - Branch redirects when source is nonzero, else next instruction.
// - Literal load moves 8 bits to register, at most 5 bits to field.
// - Absolute jump loads the address field and continues there.
// - Taken branch replaces low 8 or low 5 counter bits by the literal.
// - Each 16-bit instruction completes within one 250 ns cycle.
// - Bit positions count left to right, LSB at position 7.
package fex_pkg;

    // ------------------------------------------------------------------
    // Widths and codes
    // ------------------------------------------------------------------
    localparam int PA_W = 13;
    localparam int AXI_AW = 8;
    localparam logic [2:0] OP_MOVE = 3'h0;
    localparam logic [2:0] OP_ADD = 3'h1;
    localparam logic [2:0] OP_AND = 3'h2;
    localparam logic [2:0] OP_XOR = 3'h3;
    localparam logic [2:0] OP_EXEC = 3'h4;
    localparam logic [2:0] OP_BNZ = 3'h5;
    localparam logic [2:0] OP_LIT = 3'h6;
    localparam logic [2:0] OP_JUMP = 3'h7;
    localparam logic [4:0] CODE_AUX = 5'h00;
    localparam logic [4:0] CODE_WORK6 = 5'h06;
    localparam logic [4:0] CODE_LEFT_BANK = 5'h07;
    localparam logic [4:0] CODE_CARRY = 5'h08;
    localparam logic [4:0] CODE_SEVENTH = 5'h09;
    localparam logic [4:0] CODE_RIGHT_BANK = 5'h0f;
    localparam logic [2:0] IDX_SEVENTH = 3'h7;
    localparam logic [2:0] LEN_FULL = 3'h0;
    localparam logic [2:0] POS_LSB = 3'h7;
    localparam logic [7:0] BYTE_FULL = 8'hff;

    // ------------------------------------------------------------------
    // Register map and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_STATE = 8'h08;
    localparam int CTRL_RUN = 0;
    localparam int CTRL_STEP = 1;
    localparam int STAT_CARRY = 16;
    localparam int STAT_RUN = 17;
    localparam int STAT_XEC = 18;
    localparam int STATE_AR_LSB = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [PA_W-1:0] PC_RESET = 13'h0000;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int T_INSTR_NS = 250;
    localparam int CLK_PERIOD_NS = 20;
    localparam int INSTR_CYC_MAX = T_INSTR_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic {FEX_FETCH, FEX_EXEC} fex_state_e;

    typedef struct packed {
        logic [2:0] op;
        logic [4:0] src;
        logic [2:0] rl;
        logic [4:0] dst;
    } fex_instr_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
        logic we;
    } fex_byte_port_s;

endpackage

// file: testbench/fex_mem_model.sv
`timescale 1ns/1ps
module fex_mem_model
    import fex_pkg::*;
(
    input wire logic aclk,
    input wire logic [PA_W-1:0] prog_addr,
    output logic [15:0] prog_data,
    output logic [7:0] io_vector_rdata,
    input wire fex_byte_port_s io_vector_wr,
    output logic [7:0] scratch_store_rdata,
    input wire fex_byte_port_s scratch_store_wr
);
    logic [15:0] prog [0:8191];
    logic [7:0] io_mem [0:255];
    logic [7:0] ws_mem [0:255];
    // ----------------------------------------
    // Combinational reads, whole-byte writes
    // ----------------------------------------
    assign prog_data = prog[prog_addr];
    assign io_vector_rdata = io_mem[io_vector_wr.addr];
    assign scratch_store_rdata = ws_mem[scratch_store_wr.addr];
    always @(posedge aclk) begin
        if (io_vector_wr.we) begin
            io_mem[io_vector_wr.addr] <= io_vector_wr.data;
        end
        if (scratch_store_wr.we) begin
            ws_mem[scratch_store_wr.addr] <= scratch_store_wr.data;
        end
    end
    // Unloaded words jump to a trap at the top address
    initial begin
        for (int i = 0; i < 8192; i++) begin
            prog[i] = 16'hffff;
        end
        for (int i = 0; i < 256; i++) begin
            io_mem[i] = 8'h00;
            ws_mem[i] = 8'h00;
        end
    end
endmodule

// file: testbench/test_fixed_instruction_execute_unit.sv
`timescale 1ns/1ps
module test_fixed_instruction_execute_unit;
    import fex_pkg::*;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] mask;
        logic [31:0] exp;
        logic [1:0] resp;
    } fex_row_s;
    logic aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr, io_rd, ws_rd;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic [PA_W-1:0] prog_addr;
    logic [15:0] prog_data;
    fex_byte_port_s io_wr, ws_wr;
    int n_fail, checks;
    fex_row_s rows [4];
    logic [31:0] code [14];
    fex_core i_dut (
        .aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .prog_addr(prog_addr), .prog_data(prog_data),
        .io_vector_rdata(io_rd), .io_vector_wr(io_wr),
        .scratch_store_rdata(ws_rd), .scratch_store_wr(ws_wr)
    );
    fex_mem_model i_mem (
        .aclk(aclk), .prog_addr(prog_addr), .prog_data(prog_data),
        .io_vector_rdata(io_rd), .io_vector_wr(io_wr),
        .scratch_store_rdata(ws_rd), .scratch_store_wr(ws_wr)
    );
    always #10 aclk = ~aclk;
    // ----------------------------------------
    // Bus cycles and comparisons
    // ----------------------------------------
    task automatic end_sim();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t resp %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic hs(input int k);
        case (k)
            0: return awready && wready;
            1: return bvalid;
            2: return arready;
            default: return rvalid;
        endcase
    endfunction
    task automatic wait_hs(input int k);
        int n;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (n > 200) begin
                n_fail++;
                end_sim();
            end
        end while (hs(k) !== 1'b1);
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] v,
                             output logic [1:0] resp);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        wait_hs(0);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        wait_hs(1);
        resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic axi_read(input logic [7:0] a, output logic [31:0] v,
                            output logic [1:0] resp);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        wait_hs(2);
        arvalid <= 1'b0;
        wait_hs(3);
        v = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        ce = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hf;
        n_fail = 0;
        checks = 0;
        code = '{32'h0000c112, 32'h0001c705, 32'h0002cf0a, 32'h0003c0f0,
                 32'h00042182, 32'h0005021f, 32'h00060176, 32'h00077783,
                 32'h0008a30c, 32'h000ce040, 32'h00408053, 32'h00410500,
                 32'h0042e042, 32'h0043c577};
        rows = '{'{REG_STATUS, 32'hfffdffff, 32'h00010042, RESP_OKAY},
                 '{REG_STATE, 32'hffffffff, 32'h00004277, RESP_OKAY},
                 '{REG_CTRL, 32'hffffffff, 32'h00000001, RESP_OKAY},
                 '{8'h0c, 32'hffffffff, 32'h00000000, RESP_SLVERR}};
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 14; i++) begin
            i_mem.prog[code[i][28:16]] = code[i][15:0];
        end
        i_mem.io_mem[5] = 8'hff;
        chk_word({19'h0, prog_addr}, 32'h0);
        axi_read(REG_STATUS, d, r);
        chk_word(d, 32'h0);
        axi_write(8'h0c, 32'h1, r);
        chk_resp(r, RESP_SLVERR);
        axi_write(REG_CTRL, 32'h1, r);
        chk_resp(r, RESP_OKAY);
        for (int k = 0; k < 40 && d[12:0] !== 13'h042; k++) begin
            axi_read(REG_STATUS, d, r);
        end
        chk_word({19'h0, d[12:0]}, 32'h42);
        foreach (rows[i]) begin
            axi_read(rows[i].addr, d, r);
            chk_word(d & rows[i].mask, rows[i].exp);
            chk_resp(r, rows[i].resp);
        end
        chk_word({24'h0, i_mem.ws_mem[8'h0a]}, 32'h11);
        chk_word({24'h0, i_mem.io_mem[8'h05]}, 32'hf5);
        // Mid-run reset, then one single step
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(REG_STATE, d, r);
        chk_word(d, 32'h0);
        axi_write(REG_CTRL, 32'h2, r);
        chk_resp(r, RESP_OKAY);
        axi_read(REG_STATUS, d, r);
        chk_word(d & 32'hfffdffff, 32'h1);
        axi_read(REG_CTRL, d, r);
        chk_word(d, 32'h0);
        end_sim();
    end
endmodule
